// >>> inc/lcdc_defs.svh
// Purpose: Offsets, field positions, reset values and codes of the display control bank.
// Assumes: Byte-wide registers reached through a five-bit register pointer.
// Notes: Definitions only; included by bare name.
`ifndef LCDC_DEFS_SVH
`define LCDC_DEFS_SVH

`define LCDC_PTR_W 5
`define LCDC_OFS_SOFT_RESET 5'h00
`define LCDC_OFS_DISPLAY_SETUP 5'h02
`define LCDC_OFS_BLINK_INVERT 5'h03
`define LCDC_OFS_LAST 5'h17
`define LCDC_SOFT_RESET_CODE 8'h2C
`define LCDC_SOFT_RESET_NONE 8'h00

`define LCDC_DS_DRIVE_STRENGTH_SEL_BIT 4
`define LCDC_DS_RATIO_HI 3
`define LCDC_DS_RATIO_LO 2
`define LCDC_DS_BIAS_BIT 1
`define LCDC_DS_ON_BIT 0
`define LCDC_DS_MASK 8'h1F
`define LCDC_DS_RESET 8'h00

`define LCDC_BI_BLINK_HI 2
`define LCDC_BI_BLINK_LO 1
`define LCDC_BI_INV_BIT 0
`define LCDC_BI_MASK 8'h07
`define LCDC_BI_RESET 8'h00

`define LCDC_RATIO_STATIC 2'h3
`define LCDC_BLINK_OFF 2'h0
`define LCDC_DISP_CLK_HZ 32768

`endif

// >>> inc/lcdc_pkg.sv
// Purpose: Types shared by the display control bank and its users.
// Assumes: Constants live in lcdc_defs.svh.
// Notes: All state of the core is one packed struct.
package lcdc_pkg;

    // Display control outputs handed to the waveform and bias logic.
    typedef struct packed {
        logic drive_strength_sel;
        logic [3:0] backplane_en;
        logic bias_half;
        logic osc_run;
        logic display_active;
        logic outputs_grounded;
        logic inv_phase;
        logic frame_inv;
    } lcdc_cfg_type;

    // Complete state of the core.
    typedef struct packed {
        logic [2:0][2:0] sync;
        logic [2:0] filt;
        logic [7:0] disp_setup;
        logic [7:0] blink_inv;
        logic [4:0] reg_pointer;
        logic ptr_stop;
        logic bus_armed;
        logic cfg_defined;
        logic [1:0] por_wait;
        logic [31:0] blink_cnt;
        logic blank;
        logic inv_phase;
        logic clear_pulse;
        logic [7:0] rdata;
    } lcdc_state_type;

endpackage

// >>> core/lcdc_core.sv
// Purpose: Display setup registers, blink timing, inversion phase and reset control.
// Assumes: Serial bus framing decoded elsewhere; it delivers address and data byte strobes.
// Notes: Display clock, reset pin and reset strap are asynchronous pins.
// Functional notes
// - Setup bit 4 selects enhanced drive.
// - Bits 3-2 select four, three, two, static backplanes.
// - Bit 1 picks bias; ignored in static.
// - Bit 0 low means power-down, display off.
// - Blink field: off, 0.5, 1, 2 Hz.
// - Blink timed from display clock, blanks display.
// - External clock scales blink rate proportionally.
// - Second register bit 0: line or frame inversion.
// - Waveform polarity alternates per line or frame.
// - Strap high resets automatically at power-up.
// - After reset stay powered down, registers kept.
// - Power-on reset gives full start state.
// - Reset pin: same state, bus untouched, dominant.
// - Without strap, registers undefined until reset.
// - Code 2C resets registers and pointer.
`timescale 1ns/100ps
`include "lcdc_defs.svh"
module lcdc_core
    import lcdc_pkg::*;
#(
    parameter int DISP_CLK_HZ = `LCDC_DISP_CLK_HZ
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic auto_reset_enable_pin,
    input wire logic hw_reset_pin_n,
    input wire logic disp_clk_pin,
    input wire logic line_tick,
    input wire logic frame_tick,
    input wire logic bus_addr_valid,
    input wire logic [4:0] bus_addr,
    input wire logic bus_data_valid,
    input wire logic [7:0] bus_data,
    output logic [7:0] bus_rdata,
    output logic [4:0] reg_pointer,
    output logic display_clear,
    output logic cfg_defined,
    output lcdc_cfg_type cfg
);

    // Positions of the reset pin, the strap and the display clock in the filter vectors.
    localparam int SYNC_RST = 0;
    localparam int SYNC_STRAP = 1;
    localparam int SYNC_DCLK = 2;

    // State register, its next value and the decoded fields used below.
    lcdc_state_type st_r;
    lcdc_state_type st_nxt;
    logic [2:0] pin_in;
    logic hw_reset;
    logic dclk_rise;
    logic soft_reset;
    logic data_take;
    logic [1:0] ratio_sel;
    logic [1:0] blink_rate_sel;
    logic display_on;
    logic inversion_sel;
    logic strap_settled;

    // Decode the backplane ratio field into the enabled backplane lines.
    function automatic logic [3:0] backplanes(input logic [1:0] sel);
        logic [3:0] en;
        unique case (sel)
            2'h0: en = 4'hF;
            2'h1: en = 4'h7;
            2'h2: en = 4'h3;
            2'h3: en = 4'h1;
        endcase
        return en;
    endfunction

    // Half blink period in display clock edges; slower clocks stretch it in proportion.
    function automatic logic [31:0] blink_half(input logic [1:0] sel);
        logic [31:0] base;
        base = 32'(DISP_CLK_HZ);
        unique case (sel)
            2'h0: blink_half = base;
            2'h1: blink_half = base;
            2'h2: blink_half = base >> 1;
            2'h3: blink_half = base >> 2;
        endcase
    endfunction

    assign pin_in = {disp_clk_pin, auto_reset_enable_pin, hw_reset_pin_n};
    assign ratio_sel = st_r.disp_setup[`LCDC_DS_RATIO_HI:`LCDC_DS_RATIO_LO];
    assign blink_rate_sel = st_r.blink_inv[`LCDC_BI_BLINK_HI:`LCDC_BI_BLINK_LO];
    assign display_on = st_r.disp_setup[`LCDC_DS_ON_BIT];
    assign inversion_sel = st_r.blink_inv[`LCDC_BI_INV_BIT];
    assign strap_settled = st_r.sync[SYNC_STRAP][1] == st_r.sync[SYNC_STRAP][2]
        && st_r.filt[SYNC_STRAP] == st_r.sync[SYNC_STRAP][2];
    assign hw_reset = ~st_r.filt[SYNC_RST];
    assign dclk_rise = st_r.sync[SYNC_DCLK][1] & st_r.sync[SYNC_DCLK][2]
        & ~st_r.filt[SYNC_DCLK];
    assign data_take = bus_data_valid & st_r.bus_armed & ~st_r.ptr_stop;
    assign soft_reset = data_take && st_r.reg_pointer == `LCDC_OFS_SOFT_RESET
        && bus_data == `LCDC_SOFT_RESET_CODE;

    // Next state: pin filters, register writes, resets, blink and inversion.
    always_comb begin
        st_nxt = st_r;
        st_nxt.clear_pulse = 1'b0;
        // Three flops per pin; a change counts once the second and third agree.
        for (int i = 0; i < 3; i++) begin
            st_nxt.sync[i] = {st_r.sync[i][1:0], pin_in[i]};
            if (st_r.sync[i][1] == st_r.sync[i][2]) begin
                st_nxt.filt[i] = st_r.sync[i][2];
            end
        end
        // Strap is read once its flops and its filter agree after release.
        // The count holds at its last step until then, so a strap tied low is
        // never taken for the high level its flops rest at during reset.
        if (st_r.por_wait != 2'h0) begin
            if (st_r.por_wait != 2'h1 || strap_settled) begin
                st_nxt.por_wait = st_r.por_wait - 2'h1;
            end
            if (st_r.por_wait == 2'h1 && strap_settled && st_r.filt[SYNC_STRAP]) begin
                st_nxt.cfg_defined = 1'b1;
            end
        end
        if (bus_addr_valid) begin
            st_nxt.reg_pointer = bus_addr;
            st_nxt.ptr_stop = bus_addr > `LCDC_OFS_LAST;
            st_nxt.bus_armed = 1'b1;
        end else if (data_take) begin
            if (st_r.reg_pointer == `LCDC_OFS_DISPLAY_SETUP) begin
                st_nxt.disp_setup = bus_data & `LCDC_DS_MASK;
            end
            if (st_r.reg_pointer == `LCDC_OFS_BLINK_INVERT) begin
                st_nxt.blink_inv = bus_data & `LCDC_BI_MASK;
            end
            // Other codes at the reset slot only advance the pointer.
            if (st_r.reg_pointer == `LCDC_OFS_LAST) begin
                st_nxt.ptr_stop = 1'b1;
            end else begin
                st_nxt.reg_pointer = st_r.reg_pointer + 5'h01;
            end
        end
        // Blink: count display clock edges; nothing runs while powered down.
        if (!display_on || blink_rate_sel == `LCDC_BLINK_OFF) begin
            st_nxt.blink_cnt = 32'h0;
            st_nxt.blank = 1'b0;
        end else if (dclk_rise) begin
            if (st_r.blink_cnt + 32'h1 >= blink_half(blink_rate_sel)) begin
                st_nxt.blink_cnt = 32'h0;
                st_nxt.blank = ~st_r.blank;
            end else begin
                st_nxt.blink_cnt = st_r.blink_cnt + 32'h1;
            end
        end
        // Polarity flips each line or each frame to cancel DC.
        if (display_on && (inversion_sel ? frame_tick : line_tick)) begin
            st_nxt.inv_phase = ~st_r.inv_phase;
        end
        // Soft and pin resets load the start state; the pin leaves the bus alone.
        if (soft_reset || hw_reset) begin
            st_nxt.disp_setup = `LCDC_DS_RESET;
            st_nxt.blink_inv = `LCDC_BI_RESET;
            st_nxt.reg_pointer = `LCDC_OFS_SOFT_RESET;
            st_nxt.ptr_stop = 1'b0;
            st_nxt.blink_cnt = 32'h0;
            st_nxt.blank = 1'b0;
            st_nxt.inv_phase = 1'b0;
            st_nxt.clear_pulse = 1'b1;
            st_nxt.cfg_defined = 1'b1;
        end
        // Read path returns defined bits; reserved bits and the reset slot read zero.
        unique case (st_nxt.reg_pointer)
            `LCDC_OFS_DISPLAY_SETUP: st_nxt.rdata = st_nxt.disp_setup;
            `LCDC_OFS_BLINK_INVERT: st_nxt.rdata = st_nxt.blink_inv;
            default: st_nxt.rdata = 8'h00;
        endcase
    end

    // Power-on reset: the full start state, including a disarmed bus that waits for an address byte.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
            st_r.sync <= 9'h03F; // Display clock flops rest low like its idle pin.
            st_r.filt <= 3'h3;
            st_r.por_wait <= 2'h3;
            st_r.clear_pulse <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs; the display goes dark in power-down and during blank-out.
    assign bus_rdata = st_r.rdata;
    assign reg_pointer = st_r.reg_pointer;
    assign display_clear = st_r.clear_pulse;
    assign cfg_defined = st_r.cfg_defined;
    assign cfg.drive_strength_sel = st_r.disp_setup[`LCDC_DS_DRIVE_STRENGTH_SEL_BIT];
    assign cfg.backplane_en = backplanes(ratio_sel);
    assign cfg.bias_half = st_r.disp_setup[`LCDC_DS_BIAS_BIT]
        && ratio_sel != `LCDC_RATIO_STATIC;
    assign cfg.osc_run = display_on;
    assign cfg.display_active = display_on & ~st_r.blank;
    assign cfg.outputs_grounded = ~(display_on & ~st_r.blank);
    assign cfg.inv_phase = st_r.inv_phase;
    assign cfg.frame_inv = inversion_sel;

    // Checks run on the system clock and rest while power-on reset is applied.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // The reset code arriving at the reset slot, and the start state it leaves.
    sequence s_code_write;
        data_take && st_r.reg_pointer == `LCDC_OFS_SOFT_RESET
            && bus_data == `LCDC_SOFT_RESET_CODE;
    endsequence

    sequence s_start_state;
        st_r.disp_setup == 8'h00 && st_r.blink_inv == 8'h00 && st_r.reg_pointer == 5'h00;
    endsequence

    a_soft_reset_start: assert property (s_code_write |=> s_start_state ##0 display_clear)
        else $error("soft reset code did not restore start state");
    a_bad_code_ignored: assert property (data_take && st_r.reg_pointer == 5'h00
        && bus_data != `LCDC_SOFT_RESET_CODE && !hw_reset && !bus_addr_valid
        |=> $stable(st_r.disp_setup) && $stable(st_r.blink_inv) && reg_pointer == 5'h01)
        else $error("non-reset code changed registers");
    a_pin_reset_start: assert property (hw_reset && !bus_addr_valid |=> s_start_state)
        else $error("reset pin did not restore start state");
    a_static_bias_off: assert property (ratio_sel == 2'h3 |-> !cfg.bias_half
        && cfg.backplane_en == 4'h1)
        else $error("static drive mode with bias or extra backplanes");
    a_power_down_dark: assert property (!display_on |-> cfg.outputs_grounded
        && !cfg.osc_run && !cfg.display_active)
        else $error("power-down did not darken display");
    a_blink_off_steady: assert property (blink_rate_sel == 2'h0 |=> !st_r.blank
        || blink_rate_sel != 2'h0)
        else $error("blank-out while blinking is off");
    a_blank_dark: assert property (st_r.blank |-> !cfg.display_active)
        else $error("display active during blank-out");
    a_pointer_stops: assert property (data_take && reg_pointer == 5'h17 && !hw_reset
        && !bus_addr_valid |=> st_r.ptr_stop && reg_pointer == 5'h17)
        else $error("pointer did not stop after last register");
    a_frame_flip: assert property (display_on && inversion_sel && frame_tick
        && !hw_reset && !soft_reset |=> st_r.inv_phase != $past(st_r.inv_phase))
        else $error("frame inversion phase did not flip");
    a_line_flip: assert property (display_on && !inversion_sel && line_tick
        && !hw_reset && !soft_reset |=> st_r.inv_phase != $past(st_r.inv_phase))
        else $error("line inversion phase did not flip");
    a_phase_idle: assert property (!display_on && !hw_reset && !soft_reset
        |=> $stable(st_r.inv_phase))
        else $error("inversion phase moved while powered down");

    // A cycle in which no address byte or reset overrides a data strobe.
    sequence s_bus_quiet;
        !hw_reset && !soft_reset && !bus_addr_valid;
    endsequence

    // Writes land one cycle after the strobe, with reserved bits dropped.
    a_setup_write: assert property (s_bus_quiet ##0 data_take
        && st_r.reg_pointer == `LCDC_OFS_DISPLAY_SETUP
        |=> st_r.disp_setup == ($past(bus_data) & `LCDC_DS_MASK))
        else $error("display setup write did not land");
    a_blink_write: assert property (s_bus_quiet ##0 data_take
        && st_r.reg_pointer == `LCDC_OFS_BLINK_INVERT
        |=> st_r.blink_inv == ($past(bus_data) & `LCDC_BI_MASK))
        else $error("blink and inversion write did not land");

    // Pointer: address bytes load it, data advances it, a stopped pointer refuses data.
    a_addr_loads: assert property (bus_addr_valid && !hw_reset && !soft_reset
        |=> reg_pointer == $past(bus_addr))
        else $error("address byte did not load the pointer");
    a_addr_over_stops: assert property (bus_addr_valid && bus_addr > `LCDC_OFS_LAST
        && !hw_reset && !soft_reset |=> st_r.ptr_stop)
        else $error("address beyond the last register did not stop the pointer");
    a_pointer_advance: assert property (s_bus_quiet ##0 data_take
        && st_r.reg_pointer != `LCDC_OFS_LAST
        |=> reg_pointer == $past(st_r.reg_pointer) + 5'h01)
        else $error("data byte did not advance the pointer");
    a_stopped_refuses: assert property (s_bus_quiet ##0 bus_data_valid && st_r.ptr_stop
        |=> $stable(reg_pointer) && $stable(st_r.disp_setup) && $stable(st_r.blink_inv))
        else $error("stopped pointer accepted data");

    // Resets mark the registers defined, clear blink and phase, and pulse the clear.
    a_reset_defines: assert property (hw_reset || soft_reset |=> cfg_defined
        && display_clear)
        else $error("reset did not define registers or clear the display");
    a_soft_clears_state: assert property (s_code_write |=> !st_r.blank
        && st_r.blink_cnt == 32'h0 && !st_r.inv_phase)
        else $error("soft reset left blink or phase state behind");
    a_clear_only_reset: assert property (!hw_reset && !soft_reset |=> !display_clear)
        else $error("display clear without a reset");

    // While blinking runs, blink state changes only on a counted display clock edge.
    sequence s_blink_running;
        display_on && blink_rate_sel != `LCDC_BLINK_OFF && !hw_reset && !soft_reset;
    endsequence

    a_clock_edge_once: assert property (dclk_rise |=> !dclk_rise)
        else $error("display clock edge counted twice");
    a_blank_on_edge: assert property (s_blink_running ##0 !dclk_rise
        |=> $stable(st_r.blank) && $stable(st_r.blink_cnt))
        else $error("blink state moved without a display clock edge");
    a_count_bounded: assert property (st_r.blink_cnt < 32'(DISP_CLK_HZ))
        else $error("blink counter beyond one half period");

endmodule

// >>> bench/lcdc_host.sv
// Purpose: Host controller model driving the register bus strobes and the reset pin.
// Assumes: Strobes change 1 ns after a rising edge and are held across one sampling edge.
// Notes: Released lines show the inverse of their last value, so stale data never matches.
`timescale 1ns/100ps
module lcdc_host (
    input wire logic clock,
    output logic bus_addr_valid,
    output logic [4:0] bus_addr,
    output logic bus_data_valid,
    output logic [7:0] bus_data,
    output logic hw_reset_pin_n
);
    // Idle values at time zero; the reset pin rests high.
    initial begin
        bus_addr_valid = 1'b0;
        bus_addr = 5'h00;
        bus_data_valid = 1'b0;
        bus_data = 8'h00;
        hw_reset_pin_n = 1'b1;
    end
    // Address byte after a new start repoints the bank.
    task automatic put_addr(input logic [4:0] a);
        @(posedge clock);
        #1 bus_addr = a;
        bus_addr_valid = 1'b1;
        @(posedge clock);
        #1 bus_addr_valid = 1'b0;
        bus_addr = ~a;
    endtask
    // Data byte; callers keep reserved bits at zero.
    task automatic put_data(input logic [7:0] d);
        @(posedge clock);
        #1 bus_data = d;
        bus_data_valid = 1'b1;
        @(posedge clock);
        #1 bus_data_valid = 1'b0;
        bus_data = ~d;
    endtask
    // Reset pin low for 10 us, which is 1000 cycles at 100 MHz.
    task automatic pin_reset();
        @(posedge clock);
        #1 hw_reset_pin_n = 1'b0;
        repeat (1000) @(posedge clock);
        #1 hw_reset_pin_n = 1'b1;
    endtask
endmodule

// >>> bench/tb_lcdc_display_control_and_reset.sv
// Purpose: Self-checking bench of the display control bank.
// Assumes: Strap high, so power-on reset counts as a valid reset, until the last test.
// Notes: Display clock shortened to 8 edges per second to keep blink runs short.
`timescale 1ns/100ps
`include "lcdc_defs.svh"
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("wrong value at %0t: got %0h expected %0h", $time, g, e); \
    end \
end
module tb_lcdc_display_control_and_reset import lcdc_pkg::*; ;
    typedef struct packed {
        logic [7:0] ds;
        logic [7:0] bi;
        logic [7:0] exp;
    } lcdc_row_type;
    localparam int HZ = 8;
    localparam logic [4:0] DS = `LCDC_OFS_DISPLAY_SETUP;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic disp_clk_pin = 1'b0;
    logic line_tick = 1'b0;
    logic frame_tick = 1'b0;
    logic strap = 1'b1;
    logic bus_addr_valid, bus_data_valid, hw_reset_pin_n, display_clear, cfg_defined, ph;
    logic [4:0] bus_addr, reg_pointer;
    logic [7:0] bus_data, bus_rdata, cfg_view;
    lcdc_cfg_type cfg;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // Rows: setup byte, blink byte, expected {drive, backplanes, bias, active, frame}.
    lcdc_row_type rows[5] = '{'{8'h11, 8'h00, 8'hFA}, '{8'h07, 8'h01, 8'h3F},
        '{8'h09, 8'h00, 8'h1A}, '{8'h0F, 8'h01, 8'h0B}, '{8'h16, 8'h00, 8'hBC}};
    assign cfg_view = {cfg.drive_strength_sel, cfg.backplane_en, cfg.bias_half,
        cfg.display_active, cfg.frame_inv};
    always #5 clock = ~clock;
    lcdc_core #(.DISP_CLK_HZ(HZ)) u_lcdc_core (.clock(clock), .arst_n(arst_n),
        .auto_reset_enable_pin(strap), .hw_reset_pin_n(hw_reset_pin_n),
        .disp_clk_pin(disp_clk_pin), .line_tick(line_tick), .frame_tick(frame_tick),
        .bus_addr_valid(bus_addr_valid), .bus_addr(bus_addr), .bus_data_valid(bus_data_valid),
        .bus_data(bus_data), .bus_rdata(bus_rdata), .reg_pointer(reg_pointer),
        .display_clear(display_clear), .cfg_defined(cfg_defined), .cfg(cfg));
    lcdc_host u_lcdc_host (.clock(clock), .bus_addr_valid(bus_addr_valid),
        .bus_addr(bus_addr), .bus_data_valid(bus_data_valid), .bus_data(bus_data),
        .hw_reset_pin_n(hw_reset_pin_n));
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Writes both setup registers in one auto-incrementing burst.
    task automatic write2(logic [4:0] a, logic [7:0] d0, logic [7:0] d1);
        u_lcdc_host.put_addr(a);
        u_lcdc_host.put_data(d0);
        u_lcdc_host.put_data(d1);
        step(1);
    endtask
    task automatic peek(logic [4:0] a);
        u_lcdc_host.put_addr(a);
        step(1);
    endtask
    // Slow display clock edges; the wait at the end covers the pin filter.
    task automatic disp_edges(int n);
        repeat (n) begin
            step(3);
            disp_clk_pin = 1'b1;
            step(3);
            disp_clk_pin = 1'b0;
        end
        step(6);
    endtask
    task automatic tick(int frame);
        if (frame != 0) frame_tick = 1'b1;
        else line_tick = 1'b1;
        step(1);
        frame_tick = 1'b0;
        line_tick = 1'b0;
        step(2);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 1400 cycles the tests need.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        #1 arst_n = 1'b1;
        step(4);
        `CHK({cfg.backplane_en, cfg.bias_half, cfg.osc_run, cfg.outputs_grounded}, 7'h79)
        `CHK({reg_pointer, cfg_defined}, 6'h01)
        $display("test power-on reset done");
        foreach (rows[i]) begin
            write2(DS, rows[i].ds, rows[i].bi);
            `CHK(cfg_view, rows[i].exp)
            `CHK(cfg.osc_run, rows[i].ds[0])
            `CHK(reg_pointer, 5'h04)
            peek(DS);
            `CHK(bus_rdata, rows[i].ds)
            peek(`LCDC_OFS_BLINK_INVERT);
            `CHK(bus_rdata, rows[i].bi)
        end
        $display("test setup table done");
        write2(DS, 8'h11, 8'h00);
        u_lcdc_host.put_addr(`LCDC_OFS_SOFT_RESET);
        u_lcdc_host.put_data(8'h2B);
        step(1);
        `CHK(reg_pointer, 5'h01)
        peek(DS);
        `CHK(bus_rdata, 8'h11)
        u_lcdc_host.put_addr(`LCDC_OFS_SOFT_RESET);
        u_lcdc_host.put_data(`LCDC_SOFT_RESET_CODE);
        `CHK(display_clear, 1'b1)
        step(1);
        `CHK({display_clear, reg_pointer, cfg.backplane_en}, 10'h00F)
        peek(DS);
        `CHK(bus_rdata, 8'h00)
        $display("test soft reset done");
        for (int c = 1; c < 4; c++) begin
            write2(DS, 8'h00, 8'h00);
            write2(DS, 8'h01, 8'(c << 1));
            disp_edges((HZ >> (c - 1)) - 1);
            `CHK(cfg.display_active, 1'b1)
            disp_edges(1);
            `CHK(cfg.display_active, 1'b0)
            disp_edges(HZ >> (c - 1));
            `CHK(cfg.display_active, 1'b1)
        end
        $display("test blink done");
        for (int v = 0; v < 2; v++) begin
            write2(DS, 8'h01, 8'(v));
            ph = cfg.inv_phase;
            tick(v);
            `CHK(cfg.inv_phase, ~ph)
            tick(1 - v);
            `CHK(cfg.inv_phase, ~ph)
        end
        $display("test inversion done");
        u_lcdc_host.put_addr(`LCDC_OFS_LAST);
        u_lcdc_host.put_data(8'h00);
        u_lcdc_host.put_data(8'h00);
        step(1);
        `CHK(reg_pointer, `LCDC_OFS_LAST)
        u_lcdc_host.put_addr(5'h1F);
        u_lcdc_host.put_data(8'h00);
        step(1);
        `CHK(reg_pointer, 5'h1F)
        $display("test pointer stop done");
        write2(DS, 8'h11, 8'h00);
        u_lcdc_host.pin_reset();
        step(6);
        `CHK({cfg.backplane_en, cfg.osc_run, cfg.outputs_grounded, reg_pointer}, 11'h7A0)
        u_lcdc_host.put_data(`LCDC_SOFT_RESET_NONE);
        step(1);
        `CHK(reg_pointer, 5'h01)
        peek(DS);
        `CHK(bus_rdata, 8'h00)
        $display("test pin reset done");
        strap = 1'b0;
        arst_n = 1'b0;
        step(3);
        arst_n = 1'b1;
        step(6);
        `CHK({cfg_defined, reg_pointer, display_clear}, 7'h00)
        u_lcdc_host.put_addr(`LCDC_OFS_SOFT_RESET);
        u_lcdc_host.put_data(`LCDC_SOFT_RESET_CODE);
        step(1);
        `CHK({cfg_defined, reg_pointer}, 6'h20)
        $display("test strap low done");
        results();
    end
endmodule
